// ==== sim/ccfe_sensor_model.sv ====
// ccfe_sensor_model: behavioural image sensor on the parallel pixel link
// assumes one task call at a time; the sync wires are resolved here
`timescale 1ns/10ps
module ccfe_sensor_model
  import ccfe_pkg::*;
(
  output logic pixel_clock_in, // pclk
  output logic [PIX_W-1:0] pixel_data_in, // bus
  input wire logic frame_sync_out, // fv drive
  input wire logic frame_sync_oe_n, // fv enable
  input wire logic line_sync_out, // lv drive
  input wire logic line_sync_oe_n, // lv enable
  output logic frame_sync_in, // fv wire
  output logic line_sync_in // lv wire
);
  logic fv;
  logic lv;
  assign frame_sync_in = frame_sync_oe_n ? fv : frame_sync_out;
  assign line_sync_in = line_sync_oe_n ? lv : line_sync_out;
  initial begin
    pixel_clock_in = 1'b0;
    pixel_data_in = '0;
    fv = 1'b0;
    lv = 1'b0;
  end
  // clock runs only inside calls; pins move at the falling edge
  task automatic tick(input int n);
    repeat (n) begin
      #24 pixel_clock_in = 1'b1;
      #24 pixel_clock_in = 1'b0;
    end
  endtask
  // inverted junk outside lines makes any stray capture visible
  task automatic frame(input int rows, input int cols, input logic [PIX_W-1:0] px[$]);
    int k;
    k = 0;
    // odd start offset keeps pixel edges away from the system clock edges
    #5;
    tick(3);
    fv = 1'b1;
    tick(3);
    repeat (rows) begin
      lv = 1'b1;
      repeat (cols) begin
        pixel_data_in = px[k];
        k++;
        tick(1);
      end
      lv = 1'b0;
      pixel_data_in = ~pixel_data_in;
      tick(2);
    end
    fv = 1'b0;
    tick(8);
  endtask
endmodule

// ==== sim/ccfe_tb_top.sv ====
// ccfe_tb_top: self-checking bench for the camera capture front end
// assumes the sensor model and the bound checker are compiled first
`timescale 1ns/10ps
module ccfe_tb_top;
  import ccfe_pkg::*;
  localparam int HA = 4;
  logic clk_sys, reset_n, ce, pixel_clock_in, frame_sync_in, frame_sync_out, frame_sync_oe_n;
  logic line_sync_in, line_sync_out, line_sync_oe_n, sensor_master_clock, sync_master, bits_10;
  logic slice_high, scale_en, dead_fix_en, compand_en, out_valid, out_sof, overflow;
  logic [PIX_W-1:0] pixel_data_in, black_level;
  logic [MCLK_DIV_W-1:0] mclk_div;
  logic [31:0] out_word;
  ccfe_mode_e mode;
  ccfe_vfmt_e vfmt;
  logic [PIX_W-1:0] px[$];
  logic [31:0] ex[$], got[$];
  logic sofs[$];
  int error_cnt = 0;
  int n_tests = 0;
  wire [2:0] watch = {frame_sync_out, line_sync_out, sensor_master_clock};

  ccfe_top #(.H_TOTAL(8), .H_ACTIVE(HA), .V_TOTAL(6), .V_ACTIVE(3)) DUT (.*);
  ccfe_sensor_model sensor (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reset_n === 1'b1 && out_valid === 1'b1) begin
      got.push_back(out_word);
      sofs.push_back(out_sof);
    end
  end

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the pixel side needs its own clock edges to enter reset
  task automatic do_reset;
    reset_n = 1'b0;
    fork
      repeat (6) step;
      sensor.tick(5);
    join
    step;
    reset_n = 1'b1;
  endtask
  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    while (watch[s] !== v && n < 999) begin
      step;
      n++;
    end
    if (n >= 999) begin
      error_cnt++;
      $display("BAD wait level %0d expected %0d seen timeout", s, v);
    end
  endtask
  task automatic run_frame(input int rows, input int cols);
    got.delete();
    sofs.delete();
    sensor.frame(rows, cols, px);
    repeat (20) step;
    chk("word count", ex.size(), got.size());
    foreach (got[i]) begin
      chk("word", ex[i], got[i]);
      chk("sof", i == 0, sofs[i]);
    end
  endtask

  task automatic t_mclk;
    logic [7:0] dv[3] = '{8'h00, 8'h02, 8'h05};
    int a, b;
    foreach (dv[i]) begin
      mclk_div = dv[i];
      repeat (30) step;
      wait_lvl(0, 1'b0, a);
      wait_lvl(0, 1'b1, a);
      wait_lvl(0, 1'b0, a);
      wait_lvl(0, 1'b1, b);
      chk("mclk period", 2 * (dv[i] + 1), a + b);
    end
  endtask
  task automatic t_ycc;
    logic [9:0] v[4] = '{10'h3c5, 10'h1a6, 10'h2f7, 10'h088};
    for (int c = 0; c < 3; c++) begin
      bits_10 = c != 0;
      slice_high = c != 1;
      px.delete();
      ex = '{32'h0, 32'h0};
      for (int i = 0; i < 8; i++) begin
        px.push_back(v[i % 4]);
        ex[i / 4][8 * (i % 4) +: 8] = c == 2 ? v[i % 4][9:2] : v[i % 4][7:0];
      end
      run_frame(2, 4);
    end
    scale_en = 1'b1;
    px = '{10'h3c5, 10'h1a6, 10'h2f7, 10'h088, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff};
    ex = '{32'h22bd_69f1};
    run_frame(1, 8);
    scale_en = 1'b0;
  endtask
  task automatic t_still;
    mode = MODE_RAW_STILL;
    black_level = 10'h010;
    px = '{10'h008, 10'h2f0, 10'h3fe, 10'h011};
    ex = '{32'h02e0_0000, 32'h0001_03ee};
    run_frame(1, 4);
    black_level = 10'h000;
    compand_en = 1'b1;
    px = '{10'h020, 10'h100, 10'h300, 10'h13f};
    ex = '{32'hbfdc_a020};
    run_frame(1, 4);
    dead_fix_en = 1'b1;
    px = '{10'h020, 10'h030, 10'h000, 10'h3ff};
    ex = '{32'h3020_3020};
    run_frame(1, 4);
  endtask
  task automatic t_video;
    mode = MODE_RAW_VIDEO;
    dead_fix_en = 1'b0;
    compand_en = 1'b0;
    px = '{10'h010, 10'h020, 10'h020, 10'h030};
    ex = '{32'h0010_2030};
    run_frame(2, 2);
    vfmt = VFMT_YCC422;
    px = '{10'h020, 10'h010, 10'h020, 10'h010, 10'h010, 10'h030, 10'h010, 10'h030};
    ex = '{32'h821c_8a1c};
    run_frame(2, 4);
  endtask
  task automatic t_ovf;
    do_reset;
    chk("overflow", 0, overflow);
    mode = MODE_YCC;
    ce = 1'b0;
    px.delete();
    for (int i = 0; i < 16; i++) px.push_back(10'(i));
    sensor.frame(1, 16, px);
    step;
    ce = 1'b1;
    repeat (20) step;
    chk("overflow", 1, overflow);
    do_reset;
    chk("overflow", 0, overflow);
  endtask
  task automatic t_sync;
    int n;
    mclk_div = 8'h00;
    sync_master = 1'b1;
    wait_lvl(2, 1'b1, n);
    chk("frame drive", 1, n < 999);
    chk("frame oe_n", 0, frame_sync_oe_n);
    wait_lvl(1, 1'b0, n);
    wait_lvl(1, 1'b1, n);
    wait_lvl(1, 1'b0, n);
    chk("line width", HA * 2, n);
    sync_master = 1'b0;
    repeat (3) step;
    chk("oe_n", 1, frame_sync_oe_n & line_sync_oe_n);
  endtask

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    sync_master = 1'b0;
    bits_10 = 1'b0;
    slice_high = 1'b0;
    scale_en = 1'b0;
    dead_fix_en = 1'b0;
    compand_en = 1'b0;
    mclk_div = 8'h01;
    mode = MODE_YCC;
    vfmt = VFMT_RGB888;
    black_level = 10'h000;
    step;
    do_reset;
    t_mclk;
    t_ycc;
    t_still;
    t_video;
    t_ovf;
    t_sync;
    report_and_stop;
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
endmodule

// ==== sim/ccfe_top_sva.sv ====
// ccfe_top_sva: port checks for the camera capture front end
// assumes every watched port belongs to the clk_sys domain
`timescale 1ns/10ps
module ccfe_top_sva
  import ccfe_pkg::*;
#(
  parameter int H_ACTIVE = SYNC_H_ACTIVE
) (
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset
  input wire logic ce, // enable
  input wire logic frame_sync_out, // fv drive
  input wire logic frame_sync_oe_n, // fv enable
  input wire logic line_sync_out, // lv drive
  input wire logic line_sync_oe_n, // lv enable
  input wire logic sensor_master_clock, // mclk
  input wire logic [MCLK_DIV_W-1:0] mclk_div, // divider
  input wire logic out_valid, // strobe
  input wire logic out_sof, // frame start
  input wire logic overflow // sticky
);
  logic mq;
  logic armed;
  logic [MCLK_DIV_W:0] run;
  logic [MCLK_DIV_W-1:0] div_q;
  logic [CNT_W-1:0] rises;
  wire chg = sensor_master_clock != mq;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a level cut short by ce or a divider change is not measured
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mq <= 1'b0;
      armed <= 1'b0;
      run <= '0;
      rises <= '0;
    end else begin
      mq <= sensor_master_clock;
      armed <= ce && mclk_div == div_q && (armed || chg);
      run <= chg ? 9'h001 : run + 9'h001;
      rises <= line_sync_out ? rises + CNT_W'(sensor_master_clock && !mq) : '0;
    end
    div_q <= mclk_div;
  end
  chk_mclk_half: assert property (
    armed && ce && chg && mclk_div == div_q |-> run == {1'b0, mclk_div} + 9'h001)
    else $error("mclk half period wrong");
  chk_ce_freeze: assert property (!ce |=> $stable(sensor_master_clock))
    else $error("mclk moved with ce low");
  chk_valid_pulse: assert property (out_valid && ce |=> !out_valid)
    else $error("out_valid longer than one cycle");
  chk_sof_strobe: assert property ($rose(out_sof) |-> out_valid)
    else $error("out_sof without out_valid");
  chk_ovf_sticky: assert property (overflow |=> overflow)
    else $error("overflow cleared");
  chk_oe_pair: assert property (frame_sync_oe_n == line_sync_oe_n)
    else $error("sync enables differ");
  chk_slave_quiet: assert property (frame_sync_oe_n |-> !frame_sync_out && !line_sync_out)
    else $error("sync driven while not master");
  chk_line_width: assert property (!line_sync_oe_n && line_sync_out |-> rises <= H_ACTIVE)
    else $error("line sync too long");
  cov_word_sof: cover property (out_valid && out_sof);
  cov_ovf: cover property ($rose(overflow));
  cov_line: cover property (!line_sync_oe_n && $fell(line_sync_out));
endmodule

bind ccfe_top ccfe_top_sva #(.H_ACTIVE(H_ACTIVE)) u_sva (.*);

// ==== src/ccfe_cdc_fifo.sv ====
// ccfe_cdc_fifo: input fifo from the pixel clock domain to the system clock
// assumes each side has its own synchronous active-low reset
`timescale 1ns/10ps
module ccfe_cdc_fifo #(
  parameter int W = 12,
  parameter int AW = 3
) (
  input wire logic wr_clk, // pixel clock
  input wire logic wr_rst_n, // reset in write domain
  input wire logic wr_en, // write request
  input wire logic [W-1:0] wr_data, // write word
  output logic wr_full, // no room
  input wire logic rd_clk, // system clock
  input wire logic rd_rst_n, // reset in read domain
  input wire logic rd_ce, // read side clock enable
  input wire logic rd_en, // pop head word
  output logic [W-1:0] rd_data, // head word
  output logic rd_empty // nothing to read
);

  generate
    if (AW < 2 || W < 1) begin : g_bad
      $error("ccfe_cdc_fifo: AW must be at least 2");
    end
  endgenerate

  logic [W-1:0] mem [2**AW];
  logic [AW:0] wbin, wgray, rbin, rgray;
  logic [AW:0] rg1, rg2, wg1, wg2;

  wire [AW:0] next_wbin = wbin + 1'b1;
  wire [AW:0] next_rbin = rbin + 1'b1;
  wire do_wr = wr_en & ~wr_full;
  wire do_rd = rd_en & ~rd_empty & rd_ce;

  assign wr_full = wgray == {~rg2[AW:AW-1], rg2[AW-2:0]};
  assign rd_empty = rgray == wg2;
  assign rd_data = mem[rbin[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (do_wr) begin
      mem[wbin[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (!wr_rst_n) begin
      wbin <= '0;
      wgray <= '0;
      rg1 <= '0;
      rg2 <= '0;
    end else begin
      rg1 <= rgray;
      rg2 <= rg1;
      if (do_wr) begin
        wbin <= next_wbin;
        wgray <= next_wbin ^ (next_wbin >> 1);
      end
    end
  end

  always_ff @(posedge rd_clk) begin
    if (!rd_rst_n) begin
      rbin <= '0;
      rgray <= '0;
      wg1 <= '0;
      wg2 <= '0;
    end else if (rd_ce) begin
      wg1 <= wgray;
      wg2 <= wg1;
      if (do_rd) begin
        rbin <= next_rbin;
        rgray <= next_rbin ^ (next_rbin >> 1);
      end
    end
  end

endmodule

// ==== src/ccfe_pkg.sv ====
// ccfe_pkg: shared constants, types and helpers of the camera capture front end
// assumes nothing beyond a SystemVerilog compiler
package ccfe_pkg;

  localparam int PIX_W = 10;
  localparam int FIFO_AW = 3;
  localparam int MCLK_DIV_W = 8;
  localparam int CNT_W = 12;
  localparam int SYNC_H_TOTAL = 800;
  localparam int SYNC_H_ACTIVE = 640;
  localparam int SYNC_V_TOTAL = 525;
  localparam int SYNC_V_ACTIVE = 480;
  localparam logic [PIX_W-1:0] PIX_MAX = 10'h3ff;
  localparam logic [8:0] CHROMA_MID2 = 9'h100;
  localparam logic [2:0] UNIT_B1 = 3'h1;
  localparam logic [2:0] UNIT_B2 = 3'h2;
  localparam logic [2:0] UNIT_B4 = 3'h4;

  typedef enum logic [1:0] {
    MODE_YCC = 2'h0,
    MODE_RAW_STILL = 2'h1,
    MODE_RAW_VIDEO = 2'h3
  } ccfe_mode_e;

  typedef enum logic [1:0] {
    VFMT_RGB888 = 2'h0,
    VFMT_YCC422 = 2'h1,
    VFMT_YCC420 = 2'h3
  } ccfe_vfmt_e;

  typedef enum logic [1:0] {
    PX_IDLE = 2'h0,
    PX_FRAME = 2'h1,
    PX_LINE = 2'h3
  } ccfe_px_state_e;

  typedef struct packed {
    logic sof;
    logic sol;
    logic [PIX_W-1:0] data;
  } ccfe_pix_s;

  typedef struct packed {
    logic valid;
    logic [2:0] nbytes;
    logic [31:0] data;
  } ccfe_unit_s;

  // piecewise 10 to 8 bit curve, shared by still companding and video gamma
  function automatic logic [7:0] ccfe_compress(input logic [PIX_W-1:0] v);
    logic [PIX_W-1:0] t;
    t = 10'h000;
    if (v < 10'h040) begin
      t = v;
    end else if (v < 10'h140) begin
      t = 10'h040 + ((v - 10'h040) >> 1);
    end else begin
      t = 10'h0c0 + ((v - 10'h140) >> 4);
    end
    return t[7:0];
  endfunction

endpackage

// ==== src/ccfe_top.sv ====
// ccfe_top: parallel camera capture front end, sensor pins to packed 32-bit words
// assumes sensor pins are stable around pixel_clock_in rising edges and
// that all control inputs come from logic clocked by clk_sys
`timescale 1ns/10ps
module ccfe_top
  import ccfe_pkg::*;
#(
  parameter int H_TOTAL = SYNC_H_TOTAL,
  parameter int H_ACTIVE = SYNC_H_ACTIVE,
  parameter int V_TOTAL = SYNC_V_TOTAL,
  parameter int V_ACTIVE = SYNC_V_ACTIVE
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic ce, // freezes system-side state when low
  input wire logic pixel_clock_in, // pixel clock from sensor
  input wire logic [PIX_W-1:0] pixel_data_in, // pixel data pins
  input wire logic frame_sync_in, // frame sync pin level
  output logic frame_sync_out, // frame sync drive value
  output logic frame_sync_oe_n, // low while driving frame sync
  input wire logic line_sync_in, // line sync pin level
  output logic line_sync_out, // line sync drive value
  output logic line_sync_oe_n, // low while driving line sync
  output logic sensor_master_clock, // master clock to sensor
  input wire logic [MCLK_DIV_W-1:0] mclk_div, // half period minus one
  input wire logic sync_master, // drive syncs to the sensor
  input wire ccfe_mode_e mode, // capture mode
  input wire ccfe_vfmt_e vfmt, // raw video output format
  input wire logic bits_10, // 10-bit bus, else 8-bit on low lines
  input wire logic slice_high, // keep upper 8 of 10 bits
  input wire logic scale_en, // 2:1 reduction
  input wire logic dead_fix_en, // dead pixel substitution
  input wire logic compand_en, // 10 to 8 bit companding in still mode
  input wire logic [PIX_W-1:0] black_level, // clamp subtrahend
  output logic out_valid, // one-cycle word strobe
  output logic [31:0] out_word, // packed word
  output logic out_sof, // word holds first data of a frame
  output logic overflow // sticky fifo overflow
);

  generate
    if (H_ACTIVE >= H_TOTAL || V_ACTIVE >= V_TOTAL ||
        H_TOTAL >= 2**CNT_W || V_TOTAL >= 2**CNT_W || H_ACTIVE < 1 || V_ACTIVE < 1) begin : g_bad
      $error("ccfe_top: sync timing out of range");
    end
  endgenerate

  localparam logic [CNT_W-1:0] H_LAST = CNT_W'(H_TOTAL - 1);
  localparam logic [CNT_W-1:0] V_LAST = CNT_W'(V_TOTAL - 1);
  localparam logic [CNT_W-1:0] H_ACT = CNT_W'(H_ACTIVE);
  localparam logic [CNT_W-1:0] V_ACT = CNT_W'(V_ACTIVE);

  // ---------------- pixel clock domain ----------------
  logic prst1, prst2;
  logic [PIX_W-1:0] pd_a, pd_b;
  logic fv_a, fv_b, fv_q, lv_a, lv_b;
  logic sof_pend, px_ovf;
  ccfe_px_state_e px_state, next_px_state;
  ccfe_pix_s wr_pix;
  logic wr_full;

  always_ff @(posedge pixel_clock_in) begin
    prst1 <= reset_n;
    prst2 <= prst1;
  end

  always_ff @(posedge pixel_clock_in) begin
    pd_a <= pixel_data_in;
    pd_b <= pd_a;
    fv_a <= frame_sync_in;
    fv_b <= fv_a;
    lv_a <= line_sync_in;
    lv_b <= lv_a;
  end

  wire fv_rise = fv_b & ~fv_q;
  wire cap = fv_b & lv_b & (px_state != PX_IDLE) & prst2;
  assign wr_pix = {sof_pend, px_state == PX_FRAME, pd_b};

  always_comb begin
    next_px_state = px_state;
    case (px_state)
      PX_IDLE: begin
        if (fv_rise) begin
          next_px_state = PX_FRAME;
        end
      end
      PX_FRAME: begin
        if (!fv_b) begin
          next_px_state = PX_IDLE;
        end else if (lv_b) begin
          next_px_state = PX_LINE;
        end
      end
      PX_LINE: begin
        // line ends on line sync falling or frame sync falling; data up to the fall is kept
        if (!fv_b) begin
          next_px_state = PX_IDLE;
        end else if (!lv_b) begin
          next_px_state = PX_FRAME;
        end
      end
      default: next_px_state = PX_IDLE;
    endcase
  end

  always_ff @(posedge pixel_clock_in) begin
    if (!prst2) begin
      px_state <= PX_IDLE;
      fv_q <= 1'b1;
      sof_pend <= 1'b0;
      px_ovf <= 1'b0;
    end else begin
      px_state <= next_px_state;
      fv_q <= fv_b;
      if (fv_rise && px_state == PX_IDLE) begin
        sof_pend <= 1'b1;
      end else if (cap) begin
        sof_pend <= 1'b0;
      end
      if (cap && wr_full) begin
        px_ovf <= 1'b1;
      end
    end
  end

  // ---------------- system clock domain ----------------
  ccfe_pix_s rd_pix;
  logic rd_empty;
  wire pop = ce & ~rd_empty;

  ccfe_cdc_fifo #(.W($bits(ccfe_pix_s)), .AW(FIFO_AW)) u_fifo (
    .wr_clk(pixel_clock_in),
    .wr_rst_n(prst2),
    .wr_en(cap),
    .wr_data(wr_pix),
    .wr_full(wr_full),
    .rd_clk(clk_sys),
    .rd_rst_n(reset_n),
    .rd_ce(ce),
    .rd_en(pop),
    .rd_data(rd_pix),
    .rd_empty(rd_empty)
  );

  // master clock divider; period is 2*(mclk_div+1) system cycles
  logic [MCLK_DIV_W-1:0] mdiv_cnt;
  wire mdiv_end = mdiv_cnt == mclk_div;
  wire mclk_tick = mdiv_end & ~sensor_master_clock;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mdiv_cnt <= '0;
      sensor_master_clock <= 1'b0;
    end else if (ce) begin
      mdiv_cnt <= mdiv_end ? '0 : mdiv_cnt + 1'b1;
      if (mdiv_end) begin
        sensor_master_clock <= ~sensor_master_clock;
      end
    end
  end

  // sync generator counts master clock periods when this end drives the syncs
  logic [CNT_W-1:0] hcnt, vcnt;
  wire h_wrap = hcnt == H_LAST;
  wire [CNT_W-1:0] next_hcnt = h_wrap ? '0 : hcnt + 1'b1;
  wire [CNT_W-1:0] next_vcnt = !h_wrap ? vcnt : (vcnt == V_LAST) ? '0 : vcnt + 1'b1;
  wire next_fv = next_vcnt < V_ACT;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hcnt <= '0;
      vcnt <= '0;
      frame_sync_out <= 1'b0;
      line_sync_out <= 1'b0;
      frame_sync_oe_n <= 1'b1;
      line_sync_oe_n <= 1'b1;
    end else if (ce) begin
      frame_sync_oe_n <= ~sync_master;
      line_sync_oe_n <= ~sync_master;
      if (!sync_master) begin
        hcnt <= '0;
        vcnt <= '0;
        frame_sync_out <= 1'b0;
        line_sync_out <= 1'b0;
      end else if (mclk_tick) begin
        hcnt <= next_hcnt;
        vcnt <= next_vcnt;
        frame_sync_out <= next_fv;
        line_sync_out <= next_fv & (next_hcnt < H_ACT);
      end
    end
  end

  // position tracking; line and frame flags travel with the pixel
  logic [CNT_W-1:0] col, row;
  logic [PIX_W-1:0] hist1, hist2;
  wire [CNT_W-1:0] cur_col = (rd_pix.sof | rd_pix.sol) ? '0 : col;
  wire [CNT_W-1:0] cur_row = rd_pix.sof ? '0 : rd_pix.sol ? row + 1'b1 : row;
  wire [PIX_W-1:0] norm = bits_10 ? rd_pix.data : {rd_pix.data[7:0], 2'h0};

  // dead pixel: stuck at zero or full scale, replaced by previous same colour
  wire is_dead = dead_fix_en & ((norm == '0) | (norm == PIX_MAX)) & (|cur_col[CNT_W-1:1]);
  wire [PIX_W-1:0] fixed = is_dead ? hist2 : norm;
  wire [PIX_W-1:0] clamped = (fixed > black_level) ? fixed - black_level : '0;
  wire [7:0] cmp8 = ccfe_compress(clamped);

  // 2:1 reduction keeps whole Bayer quads so colour phase survives
  wire keep_v = ~scale_en | (~cur_col[1] & ~cur_row[1]);
  wire qbit = scale_en ? cur_col[2] : cur_col[1];
  wire rbit = scale_en ? cur_row[2] : cur_row[1];
  wire is_r = ~cur_row[0] & ~cur_col[0];
  wire is_b = cur_row[0] & cur_col[0];
  logic [7:0] r_h, g_h;
  wire [7:0] luma = 8'((r_h >> 2) + (g_h >> 1) + (cmp8 >> 2));
  wire [8:0] cb9 = ({1'b0, cmp8} + CHROMA_MID2 - {1'b0, luma}) >> 1;
  wire [8:0] cr9 = ({1'b0, r_h} + CHROMA_MID2 - {1'b0, luma}) >> 1;
  wire [7:0] chroma = qbit ? cr9[7:0] : cb9[7:0];

  ccfe_unit_s unit;

  always_comb begin
    unit = '0;
    case (mode)
      MODE_YCC: begin
        unit.valid = pop & (~scale_en | ~cur_col[2]);
        unit.nbytes = UNIT_B1;
        unit.data = {24'h0, slice_high ? norm[9:2] : norm[7:0]};
      end
      MODE_RAW_STILL: begin
        unit.valid = pop;
        unit.nbytes = compand_en ? UNIT_B1 : UNIT_B2;
        unit.data = compand_en ? {24'h0, cmp8} : {22'h0, clamped};
      end
      MODE_RAW_VIDEO: begin
        unit.valid = pop & keep_v & is_b;
        case (vfmt)
          VFMT_RGB888: begin
            unit.nbytes = UNIT_B4;
            unit.data = {8'h0, r_h, g_h, cmp8};
          end
          VFMT_YCC420: begin
            unit.nbytes = rbit ? UNIT_B1 : UNIT_B2;
            unit.data = rbit ? {24'h0, luma} : {16'h0, chroma, luma};
          end
          default: begin
            unit.nbytes = UNIT_B2;
            unit.data = {16'h0, chroma, luma};
          end
        endcase
      end
      default: unit = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      col <= '0;
      row <= '0;
      hist1 <= '0;
      hist2 <= '0;
      r_h <= '0;
      g_h <= '0;
    end else if (pop) begin
      col <= cur_col + 1'b1;
      row <= cur_row;
      hist1 <= norm;
      hist2 <= hist1;
      if (mode == MODE_RAW_VIDEO && keep_v) begin
        if (is_r) begin
          r_h <= cmp8;
        end else if (!is_b) begin
          g_h <= cmp8;
        end
      end
    end
  end

  // packer: little-endian byte lanes; a new frame restarts alignment and
  // drops any partial word of the previous frame
  logic [2:0] pk_cnt;
  logic [31:0] pk_acc;
  logic frm_pend, pk_sof;
  logic ovf_s1, ovf_s2;
  wire restart = unit.valid & (frm_pend | (pop & rd_pix.sof));
  wire [2:0] base = restart ? 3'h0 : pk_cnt;
  wire [2:0] pk_sum = base + unit.nbytes;
  wire [31:0] next_acc = (restart ? 32'h0 : pk_acc) | (unit.data << {base, 3'h0});
  wire next_pk_sof = restart | pk_sof;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pk_cnt <= '0;
      pk_acc <= '0;
      frm_pend <= 1'b0;
      pk_sof <= 1'b0;
      out_valid <= 1'b0;
      out_word <= '0;
      out_sof <= 1'b0;
      overflow <= 1'b0;
    end else if (ce) begin
      overflow <= ovf_s2;
      out_valid <= unit.valid && pk_sum == UNIT_B4;
      if (unit.valid) begin
        frm_pend <= 1'b0;
      end else if (pop && rd_pix.sof) begin
        frm_pend <= 1'b1;
      end
      if (unit.valid) begin
        if (pk_sum == UNIT_B4) begin
          out_word <= next_acc;
          out_sof <= next_pk_sof;
          pk_cnt <= '0;
          pk_acc <= '0;
          pk_sof <= 1'b0;
        end else begin
          pk_cnt <= pk_sum;
          pk_acc <= next_acc;
          pk_sof <= next_pk_sof;
        end
      end
    end
  end

  // overflow level crosses with two flops; it only ever rises until reset

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ovf_s1 <= 1'b0;
      ovf_s2 <= 1'b0;
    end else if (ce) begin
      ovf_s1 <= px_ovf;
      ovf_s2 <= ovf_s1;
    end
  end

endmodule
